//--- verif/irq_source.sv
// Model of the external device on the interrupt pin.
// Assumes an open-drain pin with a pull-up; the bench says when to pull.
`timescale 1ns/1ps
`default_nettype none
module irq_source (
  input  wire logic pull_low_in,
  output logic      pin_n_out
);
  // Released pin rises to the pull-up level, never holds a stale low
  always_comb pin_n_out = pull_low_in ? 1'b0 : 1'b1;
endmodule : irq_source
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the external interrupt latch.
// Assumes a zero-wait APB slave and a three-flop pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
module tb import ext_irq_pkg::*;;
  logic        sys_clk_in, reset_in, vfetch, brk, bce, pull_low, pin_n, cpu_req, ev_irq;
  apb_req_s    req;
  apb_rsp_s    rsp;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch = 0, num_checks = 0, lat = 0, msk = 0, sel = 0, ackd = 0, pinhi = 1;

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  irq_source u_src (.pull_low_in(pull_low), .pin_n_out(pin_n));
  external_interrupt_latch u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .apb_req_in(req), .apb_rsp_out(rsp), .irq_pin_n_in(pin_n), .vector_fetch_in(vfetch),
    .break_state_in(brk), .break_clear_enable_in(bce), .cpu_request_out(cpu_req),
    .event_irq_out(ev_irq));

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk_in);
    req.penable <= 1'b1;
    // Response is read in the edge's own step, before the slave's updates land
    for (k = 0; k < 16; k++) begin
      @(posedge sys_clk_in);
      if (rsp.pready === 1'b1) break;
    end
    if (k == 16) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb

  // Software or vector acknowledge; level mode waits for a high pin
  task automatic ack();
    if (sel == 1 && pinhi == 0) ackd = 1;
    else lat = 0;
  endtask : ack

  task automatic wctl(input logic [3:0] d);
    apb(1'b1, STATUS_CONTROL_ADDR, ($urandom & 32'hFFFFFFF0) | 32'(d));
    msk = d[1];
    sel = d[0];
    if (d[2] && !(brk && !bce)) ack();
  endtask : wctl

  task automatic ctl();
    apb(1'b0, STATUS_CONTROL_ADDR, 32'h0);
    chk(rd, 32'(lat * 8 + msk * 2 + sel));
    chk(32'(cpu_req), 32'(lat & ~msk));
  endtask : ctl

  // Fixed wait: three synchroniser flops, edge detect and latch
  task automatic pin(input int v);
    pull_low <= (v == 0);
    repeat (6) @(posedge sys_clk_in);
    if (pinhi == 1 && v == 0) lat = 1;
    if (v == 1 && ackd == 1) begin
      lat = 0;
      ackd = 0;
    end
    pinhi = v;
  endtask : pin

  initial begin
    reset_in = 1'b1;
    req = '0;
    vfetch = 1'b0;
    brk = 1'b0;
    bce = 1'b0;
    pull_low = 1'b0;
    void'($urandom(32'h808a526e));
    repeat (20) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    ctl();
    apb(1'b0, 12'h0F0, 32'h0);
    chk(32'(er), 32'h1);
    $display("Test reset done");
    pin(0);
    ctl();
    wctl(4'h2);
    ctl();
    wctl(4'h6);
    ctl();
    pin(1);
    pin(0);
    ctl();
    wctl(4'h0);
    ctl();
    @(posedge sys_clk_in);
    vfetch <= 1'b1;
    @(posedge sys_clk_in);
    vfetch <= 1'b0;
    ack();
    ctl();
    $display("Test edge mode done");
    pin(1);
    wctl(4'h1);
    pin(0);
    wctl(4'h5);
    ctl();
    pin(1);
    ctl();
    $display("Test level mode done");
    wctl(4'h0);
    pin(0);
    brk <= 1'b1;
    wctl(4'h4);
    ctl();
    bce <= 1'b1;
    wctl(4'h4);
    brk <= 1'b0;
    ctl();
    $display("Test break done");
    pin(1);
    apb(1'b1, EVENT_STATUS_ADDR, 32'h3);
    apb(1'b1, EVENT_MASK_ADDR, 32'h1);
    @(posedge sys_clk_in);
    chk(32'(ev_irq), 32'h0);
    pin(0);
    chk(32'(ev_irq), 32'h1);
    apb(1'b1, EVENT_STATUS_ADDR, 32'h1);
    @(posedge sys_clk_in);
    chk(32'(ev_irq), 32'h0);
    $display("Test events done");
    finish_test();
  end
endmodule : tb
`default_nettype wire

//--- verilog/ext_irq_pkg.sv
// Constants, register layout and bus carriers for the external interrupt latch.
// Assumes a single 40 MHz clock and an APB master on the register side.
// Notes on behaviour
// [RL1] A low on the interrupt pin sets the request latch according to the chosen sensitivity.
// [RL2] A vector fetch of this interrupt acknowledges and clears the latch that caused it.
// [RL3] Writing one to the acknowledge bit clears the latch, unless break protection forbids it.
// [RL4] Reset clears the latch and the sensitivity select, even with the pin held low.
// [RL5] With sensitivity select at zero only falling edges count and an acknowledge clears at once.
// [RL6] With sensitivity select at one both falling edges and low levels count.
// [RL7] In level mode the latch holds until an acknowledge and a high pin have both been seen.
// [RL8] A set mask withholds the latched request from the priority logic.
// [RL9] The pending flag shows the latch whatever the mask says.
// [RL10] A falling edge after an acknowledge latches a new request.
// [RL11] Servicing an unmasked request loads the program counter from the two vector bytes.
// [RL12] In break with break clear enable at zero, acknowledge writes leave the latch alone.
// [RL13] In break with break clear enable at one, an acknowledge clears and it stays cleared.
// [RL14] The status/control byte reads zero in bits 7..4 and 2, flag in 3, mask in 1, select in 0.
// [RL15] The mask bit is read/write, one disables requests, and reset clears it.
// [RL16] The pin is synchronised and a falling edge is a high sample then a low sample.
package ext_irq_pkg;

  // The control byte sits at word index 0x1A; the word bus reaches it at four times that
  localparam logic [11:0] STATUS_CONTROL_INDEX = 12'h01A;
  localparam logic [11:0] STATUS_CONTROL_ADDR  = 12'h068;
  localparam logic [11:0] EVENT_STATUS_ADDR   = 12'h020;
  localparam logic [11:0] EVENT_MASK_ADDR     = 12'h024;
  localparam logic [15:0] VECTOR_HIGH_ADDR    = 16'hFFFA;
  localparam logic [15:0] VECTOR_LOW_ADDR     = 16'hFFFB;

  localparam int SEL_BIT     = 0;
  localparam int MASK_BIT    = 1;
  localparam int ACK_BIT     = 2;
  localparam int PENDING_BIT = 3;

  localparam logic       SELECT_RESET = 1'b0;
  localparam logic       MASK_RESET   = 1'b0;
  localparam logic       LATCH_RESET  = 1'b0;
  localparam logic [1:0] EVENT_RESET  = 2'h0;
  localparam logic [2:0] SYNC_RESET   = 3'h7;

  localparam int EV_LATCH = 0;
  localparam int EV_ACK   = 1;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage : ext_irq_pkg

//--- verilog/external_interrupt_latch.sv
// External interrupt latch with APB registers and a sticky event interrupt.
// Assumes the pin is asynchronous, break and vector fetch come from the CPU clock domain.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module external_interrupt_latch
  import ext_irq_pkg::*;
(
  input  wire logic     sys_clk_in,
  input  wire logic     reset_in,
  input  wire apb_req_s apb_req_in,
  output apb_rsp_s      apb_rsp_out,
  input  wire logic     irq_pin_n_in,
  input  wire logic     vector_fetch_in,
  input  wire logic     break_state_in,
  input  wire logic     break_clear_enable_in,
  output logic          cpu_request_out,
  output logic          event_irq_out
);

  // --------------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------------
  logic [2:0] sync_q;
  logic       pin_prev_q;
  logic       pin_level;
  logic       pin_fall;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sync_q     <= SYNC_RESET;
      pin_prev_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], irq_pin_n_in};
      // Level only moves once the two late stages agree
      if (sync_q[2] == sync_q[1]) begin
        pin_prev_q <= sync_q[2];
      end
    end
  end

  assign pin_level = (sync_q[2] == sync_q[1]) ? sync_q[2] : pin_prev_q;
  assign pin_fall  = pin_prev_q & ~pin_level; // RL16

  // --------------------------------------------------------------------------
  // Register access
  // --------------------------------------------------------------------------
  logic       access;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_mask;
  logic       sel_q;
  logic       mask_q;
  logic       latch_q;
  logic [1:0] ev_status_q;
  logic [1:0] ev_mask_q;
  logic       mapped;
  logic       sw_ack;
  logic       ack;
  logic       latch_set;

  assign access    = apb_req_in.psel & apb_req_in.penable;
  assign wr_ctrl   = access & apb_req_in.pwrite & (apb_req_in.paddr == STATUS_CONTROL_ADDR);
  assign wr_status = access & apb_req_in.pwrite & (apb_req_in.paddr == EVENT_STATUS_ADDR);
  assign wr_mask   = access & apb_req_in.pwrite & (apb_req_in.paddr == EVENT_MASK_ADDR);
  assign mapped    = (apb_req_in.paddr == STATUS_CONTROL_ADDR) |
                     (apb_req_in.paddr == EVENT_STATUS_ADDR) |
                     (apb_req_in.paddr == EVENT_MASK_ADDR);

  // Break protection gates only the software path; vector fetch still clears
  assign sw_ack = wr_ctrl & apb_req_in.pwdata[ACK_BIT] &
                  (~break_state_in | break_clear_enable_in); // RL3 RL12 RL13
  assign ack    = sw_ack | vector_fetch_in; // RL2

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sel_q  <= SELECT_RESET; // RL4
      mask_q <= MASK_RESET; // RL15
    end else if (wr_ctrl) begin
      sel_q  <= apb_req_in.pwdata[SEL_BIT];
      mask_q <= apb_req_in.pwdata[MASK_BIT]; // RL15
    end
  end

  // --------------------------------------------------------------------------
  // Request latch
  // --------------------------------------------------------------------------
  // A new edge beats a same-cycle acknowledge so no request is lost
  assign latch_set = pin_fall | (sel_q & ~pin_level); // RL1 RL5 RL6 RL10

  logic ack_seen_q;

  // Level mode: an acknowledge that lands while the pin is still low is
  // remembered, so the latch drops as soon as the pin returns high.
  // A new falling edge forgets it, since that edge needs its own acknowledge.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ack_seen_q <= LATCH_RESET;
    end else begin
      ack_seen_q <= latch_q & latch_set & ~pin_fall & (ack | ack_seen_q); // RL7
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      latch_q <= LATCH_RESET; // RL4
    end else if (latch_set) begin
      latch_q <= 1'b1; // RL1 RL7
    end else if (ack | ack_seen_q) begin
      latch_q <= 1'b0; // RL5 RL7 RL13
    end
  end

  assign cpu_request_out = latch_q & ~mask_q; // RL8 RL11

  // --------------------------------------------------------------------------
  // Sticky events
  // --------------------------------------------------------------------------
  logic [1:0] ev_hit;
  assign ev_hit = {ack & latch_q, latch_set & ~latch_q};

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ev_status_q <= EVENT_RESET;
      ev_mask_q   <= EVENT_RESET;
    end else begin
      // Set wins over write-one-to-clear
      ev_status_q <= (ev_status_q & ~(wr_status ? apb_req_in.pwdata[1:0] : 2'h0)) | ev_hit;
      if (wr_mask) begin
        ev_mask_q <= apb_req_in.pwdata[1:0];
      end
    end
  end

  assign event_irq_out = |(ev_status_q & ev_mask_q);

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  logic [31:0] rdata_q;
  logic        err_q;
  logic        ready_q;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      ready_q <= apb_req_in.psel & ~apb_req_in.penable;
      err_q   <= apb_req_in.psel & ~apb_req_in.penable & ~mapped;
      rdata_q <= 32'h0;
      if (apb_req_in.psel & ~apb_req_in.penable & ~apb_req_in.pwrite) begin
        unique case (apb_req_in.paddr)
          STATUS_CONTROL_ADDR: rdata_q <= {28'h0, latch_q, 1'b0, mask_q, sel_q}; // RL9 RL14
          EVENT_STATUS_ADDR:   rdata_q <= {30'h0, ev_status_q};
          EVENT_MASK_ADDR:     rdata_q <= {30'h0, ev_mask_q};
          default:             rdata_q <= 32'h0;
        endcase
      end
    end
  end

  logic rsp_ready;

  assign rsp_ready = ready_q & apb_req_in.psel & apb_req_in.penable;

  always_comb begin
    apb_rsp_out.pready  = rsp_ready;
    apb_rsp_out.pslverr = err_q & rsp_ready;
    apb_rsp_out.prdata  = rdata_q;
  end

  // --------------------------------------------------------------------------
  // Checks: pin path
  // --------------------------------------------------------------------------
  sync_edge_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pin_fall |-> $past(pin_level) && !pin_level) // RL16
    else $error("edge detect wrong");

  sync_reset_a: assert property (@(posedge sys_clk_in)
    reset_in |=> sync_q == SYNC_RESET && pin_prev_q) // RL16
    else $error("synchroniser not idle high after reset");

  fall_agree_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pin_fall |-> sync_q[2] == sync_q[1]) // RL16
    else $error("edge seen before stages agree");

  level_track_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sync_q[2] == sync_q[1] |=> pin_prev_q == $past(sync_q[2])) // RL16
    else $error("filtered level did not follow agreed stages");

  fall_high_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pin_level |-> !pin_fall) // RL16
    else $error("edge flagged with pin high");

  fall_single_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pin_fall |=> !pin_fall) // RL16
    else $error("one edge flagged twice");

  // --------------------------------------------------------------------------
  // Checks: request latch
  // --------------------------------------------------------------------------
  latch_reset_a: assert property (@(posedge sys_clk_in)
    reset_in |=> !latch_q && !sel_q && !mask_q) // RL4
    else $error("reset left latch or control set");

  edge_sets_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pin_fall |=> latch_q) // RL1
    else $error("falling edge not latched");

  vector_clear_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    vector_fetch_in && !latch_set |=> !latch_q) // RL2
    else $error("vector fetch did not clear");

  soft_ack_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    wr_ctrl && apb_req_in.pwdata[ACK_BIT] && !break_state_in && !latch_set |=> !latch_q) // RL3
    else $error("software ack did not clear");

  break_protect_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    break_state_in && !break_clear_enable_in && !vector_fetch_in && !ack_seen_q && latch_q
    |=> latch_q) // RL12
    else $error("latch cleared during protected break");

  level_hold_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    sel_q && !pin_level |=> latch_q) // RL6
    else $error("low level not held in level mode");

  edge_mode_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !sel_q && !latch_q && pin_level && !pin_fall ##1 !pin_fall |-> !latch_q) // RL5
    else $error("edge mode latched without edge");

  latch_rise_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(latch_q) |-> $past(latch_set)) // RL1
    else $error("latch rose with no request");

  latch_fall_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $fell(latch_q) |-> $past(ack || ack_seen_q) && !$past(latch_set)) // RL2
    else $error("latch fell with no acknowledge");

  set_beats_ack_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    latch_set |=> latch_q) // RL10
    else $error("new request lost to an acknowledge");

  level_memo_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    latch_q && sel_q && !pin_level && !pin_fall && ack |=> ack_seen_q && latch_q) // RL7
    else $error("early acknowledge not remembered");

  level_release_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ack_seen_q && !latch_set |=> !latch_q) // RL7
    else $error("latch held after ack and high pin");

  edge_no_memo_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !sel_q |=> !ack_seen_q) // RL5
    else $error("edge mode kept a deferred acknowledge");

  fall_forgets_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pin_fall |=> !ack_seen_q) // RL10
    else $error("old acknowledge applied to new edge");

  brk_blocked_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    break_state_in && !break_clear_enable_in |-> !sw_ack) // RL12
    else $error("software ack passed protected break");

  brk_allowed_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    break_state_in && break_clear_enable_in && wr_ctrl && apb_req_in.pwdata[ACK_BIT]
    |-> sw_ack) // RL13
    else $error("software ack lost in open break");

  // --------------------------------------------------------------------------
  // Checks: request and event outputs
  // --------------------------------------------------------------------------
  mask_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    cpu_request_out == (latch_q && !mask_q)) // RL8
    else $error("mask gating wrong");

  masked_quiet_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    mask_q |-> !cpu_request_out) // RL8
    else $error("masked request reached priority logic");

  ev_latch_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    latch_set && !latch_q |=> ev_status_q[EV_LATCH]) // RL1
    else $error("latch event not recorded");

  ev_ack_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ack && latch_q |=> ev_status_q[EV_ACK]) // RL2
    else $error("acknowledge event not recorded");

  ev_sticky_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ev_status_q[EV_LATCH] && !wr_status |=> ev_status_q[EV_LATCH])
    else $error("event bit dropped without a clear");

  ev_clear_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    wr_status && apb_req_in.pwdata[EV_LATCH] && !(latch_set && !latch_q)
    |=> !ev_status_q[EV_LATCH])
    else $error("event bit survived its clear");

  ev_mask_wr_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    wr_mask |=> ev_mask_q == $past(apb_req_in.pwdata[1:0]))
    else $error("event mask write lost");

  // --------------------------------------------------------------------------
  // Checks: register bus
  // --------------------------------------------------------------------------
  read_layout_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_rsp_out.pready && !apb_req_in.pwrite && apb_req_in.paddr == STATUS_CONTROL_ADDR
    |-> apb_rsp_out.prdata[7:4] == 4'h0 && !apb_rsp_out.prdata[ACK_BIT]) // RL14
    else $error("reserved bits read nonzero");

  flag_read_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_rsp_out.pready && !apb_req_in.pwrite && apb_req_in.paddr == STATUS_CONTROL_ADDR
    |-> apb_rsp_out.prdata[PENDING_BIT] == $past(latch_q)) // RL9
    else $error("pending flag read wrong");

  ctrl_read_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_rsp_out.pready && !apb_req_in.pwrite && apb_req_in.paddr == STATUS_CONTROL_ADDR
    |-> apb_rsp_out.prdata[MASK_BIT] == $past(mask_q)) // RL15
    else $error("mask read wrong");

  ctrl_write_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    wr_ctrl |=> mask_q == $past(apb_req_in.pwdata[MASK_BIT]) &&
    sel_q == $past(apb_req_in.pwdata[SEL_BIT])) // RL15
    else $error("control write lost");

  ready_first_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_req_in.psel && !apb_req_in.penable ##1 apb_req_in.psel && apb_req_in.penable
    |-> apb_rsp_out.pready)
    else $error("access phase not answered at once");

  idle_quiet_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !apb_req_in.psel |-> !apb_rsp_out.pready && !apb_rsp_out.pslverr)
    else $error("answer without a selected transfer");

  unmapped_err_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_rsp_out.pready && !mapped |-> apb_rsp_out.pslverr)
    else $error("unmapped access not refused");

  mapped_ok_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_rsp_out.pready && mapped |-> !apb_rsp_out.pslverr)
    else $error("mapped access refused");

  write_rdata_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    apb_rsp_out.pready && apb_req_in.pwrite |-> apb_rsp_out.prdata == 32'h0)
    else $error("write returned read data");

endmodule : external_interrupt_latch

`default_nettype wire
